/* File: verilog/cfw_params.svh */
// Register offsets, field positions, reset values and timing of the event unit
`ifndef CFW_PARAMS_SVH
`define CFW_PARAMS_SVH

// ****************************************
// Register offsets
// ****************************************
`define REG_SYS_EN     7'h04
`define REG_SUP_EN     7'h1c
`define REG_TRX_STAT   7'h22
`define REG_TRX_EN     7'h23
`define REG_WAKE_LVL   7'h4b
`define REG_WAKE_EN    7'h4c
`define REG_GLOBAL     7'h60
`define REG_SYS        7'h61
`define REG_SUP        7'h62
`define REG_TRX        7'h63
`define REG_WPIN       7'h64

// ****************************************
// Field positions
// ****************************************
`define SYS_BATT_START    4
`define SYS_OVERHEAT      2
`define SYS_PORT_FAULT    1
`define SYS_WATCHDOG      0
`define SUP_SECOND_OVER   4
`define SUP_EXT_OVER      3
`define SUP_SECOND_UNDER  2
`define SUP_EXT_UNDER     1
`define SUP_MAIN_UNDER    0
`define TRX_FRAME_ERR     4
`define TRX_SILENCE       2
`define TRX_FAULT         1
`define TRX_WAKE          0
`define WPIN_RISE         1
`define WPIN_FALL         0
`define TST_READY         7
`define TST_SUPPLY_LOW    1
`define TST_TIMEOUT       0
`define WAKE_LVL_BIT      1
`define GLB_WAKE          3
`define GLB_TRX           2
`define GLB_SUP           1
`define GLB_SYS           0

// ****************************************
// Masks and reset values
// ****************************************
`define SYS_ALWAYS     8'h11
`define SYS_EN_MASK    8'h06
`define SUP_EN_MASK    8'h1f
`define TRX_ALWAYS     8'h10
`define TRX_EN_MASK    8'h07
`define WAKE_EN_MASK   8'h03
`define EN_RESET       8'h00
`define CMS_ACTIVE_UV  2'h1

// ****************************************
// Timing
// ****************************************
`define CLK_PERIOD_NS  20
`define MIN_BITRATE    4400
`define DOM_BITS       11
`define DOM_TO_NS      (64'd1000000000 * `DOM_BITS / `MIN_BITRATE)
`define DOM_TO_CYCLES  (`DOM_TO_NS / `CLK_PERIOD_NS)
`define EVT_DELAY_US   400
`define EVT_DELAY_CYC  (`EVT_DELAY_US * 1000 / `CLK_PERIOD_NS)
`define RESET_HOLD     5'h10

`endif

/* File: verilog/cfw_pkg.sv */
// Types shared by the event unit
package cfw_pkg;

  typedef enum logic [2:0] {
    MODE_OFF,
    MODE_RESET,
    MODE_STANDBY,
    MODE_NORMAL,
    MODE_SLEEP,
    MODE_OVERTEMP
  } sbc_mode_t;

endpackage : cfw_pkg

/* File: verilog/txd_dominant_guard.sv */
// Transmit dominant time-out guard
`timescale 1ns/1ns
`include "cfw_params.svh"
module txd_dominant_guard #(
  parameter int LIMIT = int'(`DOM_TO_CYCLES)
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic resetn,
  // Line state
  input  wire logic txd,
  input  wire logic can_active,
  // Result
  output logic      tx_enable,
  output logic      timed_out,
  output logic      expire
);
  logic [19:0] cnt;
  logic [19:0] next_cnt;
  logic        next_timed_out;
  logic        next_expire;

  always_comb
  begin
    next_cnt       = cnt;
    next_timed_out = timed_out;
    next_expire    = 1'b0;
    if (txd)
    begin
      next_cnt       = '0;
      next_timed_out = 1'b0;
    end
    else if (can_active && !timed_out)
    begin
      if (cnt == 20'(LIMIT - 1))
      begin
        next_timed_out = 1'b1;
        next_expire    = 1'b1;
      end
      else
        next_cnt = cnt + 20'h1;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt       <= '0;
      timed_out <= 1'b0;
      expire    <= 1'b0;
    end
    else
    begin
      cnt       <= next_cnt;
      timed_out <= next_timed_out;
      expire    <= next_expire;
    end
  end

  assign tx_enable = !timed_out;

endmodule : txd_dominant_guard

/* File: verilog/wake_edge_detect.sv */
// WAKE pin edge detector
`timescale 1ns/1ns
module wake_edge_detect (
  // Clock and reset
  input  wire logic clk,
  input  wire logic resetn,
  // Pin
  input  wire logic wake_pin,
  // Edges
  output logic      level,
  output logic      rise,
  output logic      fall
);
  logic primed;

  // No edge is reported before the first sample, so a pin high at reset is not a wake
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      level  <= 1'b0;
      primed <= 1'b0;
    end
    else
    begin
      level  <= wake_pin;
      primed <= 1'b1;
    end
  end

  assign rise = primed && wake_pin && !level;
  assign fall = primed && !wake_pin && level;

endmodule : wake_edge_detect

/* File: verilog/can_failsafe_wake_event_unit.sv */
// CAN fail-safe, WAKE pin and event capture unit of the system basis chip
// Notes on behaviour
// - Transmit low too long disables transmitter
// - Transmit high resets the dominant timer
// - Time-out sized for 4.4 kbit/s minimum
// - Time-out sets CAN fault when enabled
// - Time-out reported, transmit ready cleared
// - Supply low in mode 01 flags
// - WAKE edges raise wake when enabled
// - WAKE level readable, validity by mode
// - Three events always captured, others gated
// - Enabled events set their status bit
// - Offline capture pulls receive pin low
// - Sleep capture goes Reset then Standby
// - Global register shows pending groups
// - Write one clears, zero keeps
// - One write clears many bits
// - Clear releases pin, starts delay timer
// - Expiry with pending pulls pin low
// - Expiry with nothing pending stays high
// - Event registers readable any time
// - Reset output fall stops delay timer
// - Reset output low in four modes
// - Sleep entry signals pending events
// - Global bits three to zero layout
`timescale 1ns/1ns
`include "cfw_params.svh"
module can_failsafe_wake_event_unit
  import cfw_pkg::*;
#(
  parameter int DOM_CYCLES = int'(`DOM_TO_CYCLES),
  parameter int EVT_CYCLES = int'(`EVT_DELAY_CYC)
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // Register access
  input  wire logic       reg_wr,
  input  wire logic [6:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  // CAN pins and line state
  input  wire logic       can_transmit_pin,
  input  wire logic       can_bus_rx,
  input  wire logic [1:0] can_mode_select,
  input  wire logic       can_supply_low,
  output logic            can_receive_pin,
  output logic            transmit_enable,
  // WAKE pin
  input  wire logic       wake_pin,
  // Event sources, one-cycle pulses
  input  wire logic       battery_startup_event,
  input  wire logic       overheat_warning_event,
  input  wire logic       serial_port_fault_event,
  input  wire logic       watchdog_fault_event,
  input  wire logic       second_regulator_over_event,
  input  wire logic       external_supply_over_event,
  input  wire logic       second_regulator_under_event,
  input  wire logic       external_supply_under_event,
  input  wire logic       main_regulator_under_event,
  input  wire logic       selective_frame_error_event,
  input  wire logic       bus_silence_event,
  input  wire logic       can_wake_event,
  // Mode control
  input  wire logic       sleep_cmd,
  input  wire logic       normal_cmd,
  input  wire logic       standby_cmd,
  input  wire logic       overtemp,
  input  wire logic       battery_lost,
  output sbc_mode_t       mode,
  output logic            main_regulator_on,
  output logic            reset_out_n
);

  function automatic logic [7:0] w1c_next(input logic [7:0] stat, input logic [7:0] ev,
                                          input logic [7:0] en, input logic [7:0] clr);
    // Set wins over a clear in the same cycle
    w1c_next = (stat & ~clr) | (ev & en);
  endfunction : w1c_next

  // ****************************************
  // Fail-safe and WAKE pin
  // ****************************************
  logic can_active;
  logic tx_en_raw;
  logic dom_timed_out;
  logic dom_expire;
  logic wake_level;
  logic wake_rise;
  logic wake_fall;

  assign can_active = (mode == MODE_NORMAL) && (can_mode_select != 2'h0);

  txd_dominant_guard #(.LIMIT(DOM_CYCLES)) u_guard (
    .clk        (clk),
    .resetn     (resetn),
    .txd        (can_transmit_pin),
    .can_active (can_active),
    .tx_enable  (tx_en_raw),
    .timed_out  (dom_timed_out),
    .expire     (dom_expire)
  );

  wake_edge_detect u_wake (
    .clk      (clk),
    .resetn   (resetn),
    .wake_pin (wake_pin),
    .level    (wake_level),
    .rise     (wake_rise),
    .fall     (wake_fall)
  );

  // ****************************************
  // Event status and enables
  // ****************************************
  logic [7:0] sys_stat, sup_stat, trx_stat, wpin_stat;
  logic [7:0] sys_en, sup_en, trx_en, wake_en;
  logic [7:0] next_sys_stat, next_sup_stat, next_trx_stat, next_wpin_stat;
  logic [7:0] next_sys_en, next_sup_en, next_trx_en, next_wake_en;
  logic [7:0] sys_ev, sup_ev, trx_ev, wpin_ev;
  logic [7:0] clr_sys, clr_sup, clr_trx, clr_wpin;
  logic       uv_cond;
  logic       uv_prev;
  logic       any_capture;
  logic       any_clear;
  logic       pending;

  // undervoltage only while mode select is 01
  assign uv_cond = (can_mode_select == `CMS_ACTIVE_UV) && can_supply_low;

  always_comb
  begin
    sys_ev = '0;
    sup_ev = '0;
    trx_ev = '0;
    wpin_ev = '0;
    sys_ev[`SYS_BATT_START]   = battery_startup_event;
    sys_ev[`SYS_OVERHEAT]     = overheat_warning_event;
    sys_ev[`SYS_PORT_FAULT]   = serial_port_fault_event;
    sys_ev[`SYS_WATCHDOG]     = watchdog_fault_event;
    sup_ev[`SUP_SECOND_OVER]  = second_regulator_over_event;
    sup_ev[`SUP_EXT_OVER]     = external_supply_over_event;
    sup_ev[`SUP_SECOND_UNDER] = second_regulator_under_event;
    sup_ev[`SUP_EXT_UNDER]    = external_supply_under_event;
    sup_ev[`SUP_MAIN_UNDER]   = main_regulator_under_event;
    trx_ev[`TRX_FRAME_ERR]    = selective_frame_error_event;
    trx_ev[`TRX_SILENCE]      = bus_silence_event;
    trx_ev[`TRX_WAKE]         = can_wake_event;
    // time-out or supply drop is a CAN failure
    trx_ev[`TRX_FAULT]        = dom_expire || (uv_cond && !uv_prev);
    // each edge gated by its own enable below
    wpin_ev[`WPIN_RISE] = wake_rise;
    wpin_ev[`WPIN_FALL] = wake_fall;
  end

  always_comb
  begin
    clr_sys  = (reg_wr && reg_addr == `REG_SYS)  ? reg_wdata : 8'h00;
    clr_sup  = (reg_wr && reg_addr == `REG_SUP)  ? reg_wdata : 8'h00;
    clr_trx  = (reg_wr && reg_addr == `REG_TRX)  ? reg_wdata : 8'h00;
    clr_wpin = (reg_wr && reg_addr == `REG_WPIN) ? reg_wdata : 8'h00;
    next_sys_en  = sys_en;
    next_sup_en  = sup_en;
    next_trx_en  = trx_en;
    next_wake_en = wake_en;
    if (reg_wr && reg_addr == `REG_SYS_EN)
      next_sys_en = reg_wdata & `SYS_EN_MASK;
    if (reg_wr && reg_addr == `REG_SUP_EN)
      next_sup_en = reg_wdata & `SUP_EN_MASK;
    if (reg_wr && reg_addr == `REG_TRX_EN)
      next_trx_en = reg_wdata & `TRX_EN_MASK;
    if (reg_wr && reg_addr == `REG_WAKE_EN)
      next_wake_en = reg_wdata & `WAKE_EN_MASK;
    // any number of bits per write
    next_sys_stat  = w1c_next(sys_stat, sys_ev, sys_en | `SYS_ALWAYS, clr_sys);
    next_sup_stat  = w1c_next(sup_stat, sup_ev, sup_en, clr_sup);
    next_trx_stat  = w1c_next(trx_stat, trx_ev, trx_en | `TRX_ALWAYS, clr_trx);
    next_wpin_stat = w1c_next(wpin_stat, wpin_ev, wake_en, clr_wpin);
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sys_stat  <= 8'h00;
      sup_stat  <= 8'h00;
      trx_stat  <= 8'h00;
      wpin_stat <= 8'h00;
      sys_en    <= `EN_RESET;
      sup_en    <= `EN_RESET;
      trx_en    <= `EN_RESET;
      wake_en   <= `EN_RESET;
      uv_prev   <= 1'b0;
    end
    else
    begin
      sys_stat  <= next_sys_stat;
      sup_stat  <= next_sup_stat;
      trx_stat  <= next_trx_stat;
      wpin_stat <= next_wpin_stat;
      sys_en    <= next_sys_en;
      sup_en    <= next_sup_en;
      trx_en    <= next_trx_en;
      wake_en   <= next_wake_en;
      uv_prev   <= uv_cond;
    end
  end

  assign any_capture = |{sys_ev & (sys_en | `SYS_ALWAYS), sup_ev & sup_en,
                         trx_ev & (trx_en | `TRX_ALWAYS), wpin_ev & wake_en};
  // Only a clear that hits a set bit restarts the delay
  assign any_clear = |{clr_sys & sys_stat, clr_sup & sup_stat,
                       clr_trx & trx_stat, clr_wpin & wpin_stat};
  assign pending   = |{next_sys_stat, next_sup_stat, next_trx_stat, next_wpin_stat};

  // ****************************************
  // Mode sequencing
  // ****************************************
  sbc_mode_t  next_mode;
  logic [4:0] hold;
  logic [4:0] next_hold;
  logic       next_reset_out_n;
  logic       next_main_reg;
  logic       stat_pending;

  assign stat_pending = |{sys_stat, sup_stat, trx_stat, wpin_stat};

  always_comb
  begin
    next_mode = mode;
    next_hold = 5'h0;
    unique case (mode)
      MODE_OFF:
        next_mode = MODE_RESET;
      MODE_RESET:
      begin
        next_hold = hold + 5'h1;
        if (hold == `RESET_HOLD)
          next_mode = MODE_STANDBY;
      end
      MODE_STANDBY, MODE_NORMAL:
      begin
        if (overtemp)
          next_mode = MODE_OVERTEMP;
        // A pending event blocks sleep; go through reset instead
        else if (sleep_cmd)
          next_mode = stat_pending ? MODE_RESET : MODE_SLEEP;
        else if (normal_cmd)
          next_mode = MODE_NORMAL;
        else if (standby_cmd)
          next_mode = MODE_STANDBY;
      end
      MODE_SLEEP:
        if (any_capture)
          next_mode = MODE_RESET;
      MODE_OVERTEMP:
        if (!overtemp)
          next_mode = MODE_RESET;
      // Unused codes restart from power-off
      default:
        next_mode = MODE_OFF;
    endcase
    if (battery_lost)
      next_mode = MODE_OFF;
    // reset output low in these modes
    next_reset_out_n = !(next_mode inside {MODE_RESET, MODE_SLEEP, MODE_OVERTEMP, MODE_OFF});
    next_main_reg    = !(next_mode inside {MODE_SLEEP, MODE_OFF});
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      mode              <= MODE_OFF;
      hold              <= 5'h0;
      reset_out_n       <= 1'b0;
      main_regulator_on <= 1'b0;
    end
    else
    begin
      mode              <= next_mode;
      hold              <= next_hold;
      reset_out_n       <= next_reset_out_n;
      main_regulator_on <= next_main_reg;
    end
  end

  // ****************************************
  // Event delay and receive pin
  // ****************************************
  logic [19:0] evt_cnt;
  logic [19:0] next_evt_cnt;
  logic        evt_run;
  logic        next_evt_run;
  logic        notify;
  logic        next_notify;
  logic        next_rxd;
  logic        evt_expire;
  logic        reset_out_fall;

  assign reset_out_fall = reset_out_n && !next_reset_out_n;
  assign evt_expire     = evt_run && (evt_cnt == 20'(EVT_CYCLES - 1));

  always_comb
  begin
    next_evt_run = evt_run;
    next_evt_cnt = evt_run ? evt_cnt + 20'h1 : 20'h0;
    next_notify  = notify;
    if (evt_expire)
    begin
      next_evt_run = 1'b0;
      next_notify  = pending;
    end
    if (any_clear)
    begin
      next_evt_run = 1'b1;
      next_evt_cnt = 20'h0;
      next_notify  = 1'b0;
    end
    else if (any_capture && !evt_run)
      next_notify = 1'b1;
    if (reset_out_fall)
    begin
      next_evt_run = 1'b0;
      next_evt_cnt = 20'h0;
    end
    // pending event shown on sleep entry
    if (next_mode == MODE_SLEEP && mode != MODE_SLEEP)
      next_notify = pending;
    // alert only when offline with a usable mode
    if (can_active)
      next_rxd = can_bus_rx;
    else
      next_rxd = !(next_notify && (mode inside {MODE_NORMAL, MODE_STANDBY, MODE_SLEEP}));
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      evt_cnt         <= 20'h0;
      evt_run         <= 1'b0;
      notify          <= 1'b0;
      can_receive_pin <= 1'b1;
    end
    else
    begin
      evt_cnt         <= next_evt_cnt;
      evt_run         <= next_evt_run;
      notify          <= next_notify;
      can_receive_pin <= next_rxd;
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  logic [7:0] next_rdata;
  logic [7:0] glb;
  logic [7:0] tst;
  logic [7:0] wlv;

  always_comb
  begin
    glb = 8'h00;
    tst = 8'h00;
    wlv = 8'h00;
    glb[`GLB_WAKE] = |wpin_stat;
    glb[`GLB_TRX]  = |trx_stat;
    glb[`GLB_SUP]  = |sup_stat;
    glb[`GLB_SYS]  = |sys_stat;
    tst[`TST_READY]      = can_active && !dom_timed_out;
    tst[`TST_TIMEOUT]    = dom_timed_out;
    tst[`TST_SUPPLY_LOW] = uv_cond;
    // level only valid in normal or with an edge enabled
    wlv[`WAKE_LVL_BIT] = wake_level && ((mode == MODE_NORMAL) || (|wake_en));
    unique case (reg_addr)
      `REG_SYS_EN:   next_rdata = sys_en;
      `REG_SUP_EN:   next_rdata = sup_en;
      `REG_TRX_STAT: next_rdata = tst;
      `REG_TRX_EN:   next_rdata = trx_en;
      `REG_WAKE_LVL: next_rdata = wlv;
      `REG_WAKE_EN:  next_rdata = wake_en;
      `REG_GLOBAL:   next_rdata = glb;
      `REG_SYS:      next_rdata = sys_stat;
      `REG_SUP:      next_rdata = sup_stat;
      `REG_TRX:      next_rdata = trx_stat;
      `REG_WPIN:     next_rdata = wpin_stat;
      default:       next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      reg_rdata       <= 8'h00;
      transmit_enable <= 1'b1;
    end
    else
    begin
      reg_rdata       <= next_rdata;
      transmit_enable <= tx_en_raw;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_tx_kill_expiry: assert property (dom_expire |=> !transmit_enable)
    else $error("transmitter still enabled after time-out");
  a_tx_high_reset: assert property (can_transmit_pin |=> !dom_timed_out ##1 transmit_enable)
    else $error("time-out not reset by high transmit");
  a_fault_capture: assert property (dom_expire && trx_en[`TRX_FAULT] |=> trx_stat[`TRX_FAULT])
    else $error("CAN fault not captured");
  a_wake_rise: assert property (wake_rise && wake_en[`WPIN_RISE] |=> wpin_stat[`WPIN_RISE])
    else $error("rising wake not captured");
  a_always_startup: assert property (battery_startup_event |=> sys_stat[`SYS_BATT_START])
    else $error("battery start-up not captured");
  a_w1c_clear: assert property (reg_wr && reg_addr == `REG_WPIN && reg_wdata[0] && !wpin_ev[0]
                                |=> !wpin_stat[0])
    else $error("write one did not clear");
  a_rxd_release: assert property (any_clear && !can_active |=> can_receive_pin && evt_run)
    else $error("receive pin not released on clear");
  a_timer_stop: assert property ($fell(reset_out_n) |-> !evt_run)
    else $error("delay timer runs after reset output fell");
  a_reset_out_modes: assert property (mode inside {MODE_RESET, MODE_SLEEP, MODE_OVERTEMP, MODE_OFF} |->
                                      !reset_out_n)
    else $error("reset output high in a reset-low mode");
  a_sleep_wake: assert property (mode == MODE_SLEEP && any_capture && !battery_lost
                                 |=> mode == MODE_RESET)
    else $error("sleep capture did not enter reset");
  a_global_sum: assert property (reg_addr == `REG_GLOBAL
                                 |=> reg_rdata[`GLB_SYS] == $past(|sys_stat))
    else $error("global summary mismatch");

  c_dom_timeout: cover property (dom_expire);
  c_delay_renotify: cover property (evt_expire && pending);
  c_sleep_wake: cover property (mode == MODE_SLEEP ##1 mode == MODE_RESET);

endmodule : can_failsafe_wake_event_unit

/* File: verification/host_mcu.sv */
// Host microcontroller model driving the event unit register port
`timescale 1ns/1ns
module host_mcu (
  // Clock and read data
  input  wire logic       clk,
  input  wire logic [7:0] reg_rdata,
  // Request
  output logic            reg_wr,
  output logic      [6:0] reg_addr,
  output logic      [7:0] reg_wdata
);
  initial
  begin
    reg_wr    = 1'b0;
    reg_addr  = 7'h00;
    reg_wdata = 8'h00;
  end

  task automatic wr(input logic [6:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask : wr

  // Address is taken one edge after it is set, data lands on that edge
  task automatic rd(input logic [6:0] a, output logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    @(posedge clk);
    @(posedge clk);
    v = reg_rdata;
  endtask : rd

  task automatic service(input logic [6:0] a);
    logic [7:0] seen;
    rd(a, seen);
    if (seen !== 8'h00)
      wr(a, seen);
  endtask : service
endmodule : host_mcu

/* File: verification/can_failsafe_wake_event_unit_bench.sv */
// Self-checking bench of the CAN fail-safe and event unit
`timescale 1ns/1ns
`include "cfw_params.svh"
module can_failsafe_wake_event_unit_bench;
  import cfw_pkg::*;
  localparam int DOM = 20;
  localparam int EVT = 16;
  logic        clk, resetn, can_transmit_pin, can_supply_low, wake_pin, hot, bat_lost;
  logic        reg_wr, can_receive_pin, transmit_enable, main_regulator_on, reset_out_n;
  logic [1:0]  cms;
  logic [14:0] ev;
  logic [6:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, d;
  sbc_mode_t   mode;
  int          miscompares, comparisons;

  can_failsafe_wake_event_unit #(.DOM_CYCLES(DOM), .EVT_CYCLES(EVT)) u_dut (
    .clk, .resetn, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata, .can_transmit_pin,
    .can_bus_rx(1'b1), .can_mode_select(cms), .can_supply_low, .can_receive_pin,
    .transmit_enable, .wake_pin, .battery_startup_event(ev[0]), .overheat_warning_event(ev[1]),
    .serial_port_fault_event(ev[2]), .watchdog_fault_event(ev[3]), .second_regulator_over_event(ev[4]),
    .external_supply_over_event(ev[5]), .second_regulator_under_event(ev[6]),
    .external_supply_under_event(ev[7]), .main_regulator_under_event(ev[8]),
    .selective_frame_error_event(ev[9]), .bus_silence_event(ev[10]), .can_wake_event(ev[11]),
    .sleep_cmd(ev[12]), .normal_cmd(ev[13]), .standby_cmd(ev[14]), .overtemp(hot),
    .battery_lost(bat_lost), .mode, .main_regulator_on, .reset_out_n);

  host_mcu u_host (.clk, .reg_rdata, .reg_wr, .reg_addr, .reg_wdata);

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic rchk(input logic [6:0] a, input logic [7:0] exp);
    u_host.rd(a, d);
    chk(d, exp);
  endtask : rchk

  task automatic fire(input int i);
    @(posedge clk);
    ev[i] <= 1'b1;
    @(posedge clk);
    ev    <= '0;
  endtask : fire

  task automatic wait_run;
    for (int k = 0; k < 40 && reset_out_n !== 1'b1; k++)
      @(posedge clk);
  endtask : wait_run

  task automatic test_done;
    if (miscompares == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : test_done

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Whole sequence needs well under two thousand cycles
  initial
  begin
    #(20 * 4000);
    miscompares++;
    test_done();
  end

  initial
  begin
    {resetn, cms, ev, can_supply_low, wake_pin, hot, bat_lost} = '0;
    can_transmit_pin = 1'b1;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    repeat (2) @(posedge clk);
    chk(reset_out_n, 1'b0);
    wait_run();
    chk(mode, MODE_STANDBY);
    for (int a = 'h61; a <= 'h64; a++)
      u_host.service(7'(a));
    repeat (EVT + 4) @(posedge clk);
    chk(can_receive_pin, 1'b1);
    rchk(7'h7f, 8'h00);
    u_host.wr(`REG_WAKE_LVL, 8'hff);
    rchk(`REG_WAKE_LVL, 8'h00);
    fire(1);
    fire(0);
    fire(3);
    chk(can_receive_pin, 1'b0);
    fire(9);
    rchk(`REG_SYS, 8'h11);
    rchk(`REG_TRX, 8'h10);
    rchk(`REG_GLOBAL, 8'h05);
    u_host.wr(`REG_SYS, 8'h00);
    rchk(`REG_SYS, 8'h11);
    u_host.wr(`REG_SYS_EN, 8'hff);
    u_host.wr(`REG_SYS, 8'h11);
    // The pin is released by the write edge itself, so look one edge later
    @(posedge clk);
    chk(can_receive_pin, 1'b1);
    fire(1);
    rchk(`REG_SYS, 8'h04);
    chk(can_receive_pin, 1'b1);
    repeat (EVT) @(posedge clk);
    chk(can_receive_pin, 1'b0);
    u_host.service(`REG_SYS);
    u_host.service(`REG_TRX);
    repeat (EVT + 4) @(posedge clk);
    chk(can_receive_pin, 1'b1);
    u_host.wr(`REG_SUP_EN, 8'hff);
    for (int i = 4; i <= 8; i++)
    begin
      fire(i);
      rchk(`REG_SUP, 8'h01 << (8 - i));
      u_host.wr(`REG_SUP, 8'hff);
    end
    u_host.wr(`REG_WAKE_EN, 8'h02);
    @(posedge clk);
    wake_pin <= 1'b1;
    rchk(`REG_WPIN, 8'h02);
    rchk(`REG_WAKE_LVL, 8'h02);
    rchk(`REG_GLOBAL, 8'h08);
    wake_pin <= 1'b0;
    rchk(`REG_WPIN, 8'h02);
    u_host.wr(`REG_WAKE_EN, 8'h03);
    wake_pin <= 1'b1;
    u_host.wr(`REG_WPIN, 8'h02);
    wake_pin <= 1'b0;
    rchk(`REG_WPIN, 8'h01);
    u_host.wr(`REG_TRX_EN, 8'hff);
    fire(10);
    fire(11);
    rchk(`REG_TRX, 8'h05);
    u_host.service(`REG_TRX);
    fire(13);
    cms <= 2'h1;
    can_transmit_pin <= 1'b0;
    repeat (DOM - 4) @(posedge clk);
    can_transmit_pin <= 1'b1;
    repeat (2) @(posedge clk);
    can_transmit_pin <= 1'b0;
    repeat (DOM - 4) @(posedge clk);
    chk(transmit_enable, 1'b1);
    repeat (8) @(posedge clk);
    chk(transmit_enable, 1'b0);
    rchk(`REG_TRX_STAT, 8'h01);
    rchk(`REG_TRX, 8'h02);
    u_host.wr(`REG_TRX, 8'h02);
    can_transmit_pin <= 1'b1;
    can_supply_low <= 1'b1;
    u_host.rd(`REG_TRX_STAT, d);
    chk(d & 8'h02, 8'h02);
    rchk(`REG_TRX, 8'h02);
    chk(transmit_enable, 1'b1);
    can_supply_low <= 1'b0;
    fire(14);
    cms <= 2'h0;
    for (int a = 'h61; a <= 'h64; a++)
      u_host.service(7'(a));
    // Sleep while the delay timer still runs, so its stop is exercised
    repeat (2) @(posedge clk);
    fire(12);
    repeat (4) @(posedge clk);
    chk(mode, MODE_SLEEP);
    chk(reset_out_n, 1'b0);
    wake_pin <= 1'b1;
    repeat (2) @(posedge clk);
    wait_run();
    chk(mode, MODE_STANDBY);
    chk(main_regulator_on, 1'b1);
    @(posedge clk);
    chk(can_receive_pin, 1'b0);
    hot <= 1'b1;
    repeat (2) @(posedge clk);
    chk(mode, MODE_OVERTEMP);
    chk(reset_out_n, 1'b0);
    hot      <= 1'b0;
    bat_lost <= 1'b1;
    repeat (2) @(posedge clk);
    chk(mode, MODE_OFF);
    chk(reset_out_n, 1'b0);
    chk(main_regulator_on, 1'b0);
    bat_lost <= 1'b0;
    wait_run();
    chk(mode, MODE_STANDBY);
    test_done();
  end
endmodule : can_failsafe_wake_event_unit_bench
